// >>> pve_pkg.sv
// Purpose: constants and carriers for one phase voltage protection element
// Assumes: 50 MHz pclk, APB register access, 16-bit measured magnitudes
// Notes:   per-unit fields are scaled by 1024
//
// Summary of operation
// [RL1] ground connection: message n is phase n
// [RL2] line connection: messages are 1-2, 2-3, 3-1
// [RL3] mode selects under- or overvoltage, average variant
// [RL4] method picks fundamental or true rms
// [RL5] method may pick ten-minute sliding average instead
// [RL6] measuring mode sets nominal reference, secondary/root3
// [RL7] line connection forces phase-to-phase reference
// [RL8] minimum-current check only undervoltage, needs enable
// [RL9] all currents below minimum blocks undervoltage
// [RL10] current back: unblock after release delay
// [RL11] voting: one, two or all three phases
// [RL12] settable dropout ratio gives hysteresis
// [RL13] overvoltage releases at 97 percent or lower
// [RL14] undervoltage releases at 103 percent or higher
// [RL15] trip delay timed from threshold crossing
// [RL16] under acts on falling, over on rising
// [RL17] undervoltage trip delay is settable
// [RL18] external block suppresses undervoltage tripping
// [RL19] circuit supervision plus fuse failure blocks undervoltage
// [RL20] timer restarts on dropout, trip clears then
package pve_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_VTSEC  = 8'h04;
	localparam logic [7:0] OFS_THR    = 8'h08;
	localparam logic [7:0] OFS_RATIO  = 8'h0c;
	localparam logic [7:0] OFS_TDLY   = 8'h10;
	localparam logic [7:0] OFS_IMIN   = 8'h14;
	localparam logic [7:0] OFS_IDLY   = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	// control field positions
	localparam int CB_EN    = 0;
	localparam int CB_OVER  = 1;
	localparam int CB_METH  = 2;  // two bits
	localparam int CB_VTPP  = 4;
	localparam int CB_MMPP  = 5;
	localparam int CB_VOTE  = 6;  // two bits
	localparam int CB_IMEN  = 8;
	localparam int CB_MCS   = 9;
	// reset values
	localparam logic [9:0]  RST_CTRL  = 10'h000;
	localparam logic [15:0] RST_VTSEC = 16'h0064;
	localparam logic [15:0] RST_THR   = 16'h0400;
	localparam logic [15:0] RST_RATIO = 16'h03e1;
	localparam logic [15:0] RST_TDLY  = 16'h0064;
	localparam logic [15:0] RST_IMIN  = 16'h0000;
	localparam logic [15:0] RST_IDLY  = 16'h0064;
	// fixed hysteresis limits, 97 and 103 percent of 1024
	localparam logic [15:0] RATIO_OV_MAX = 16'h03e1;
	localparam logic [15:0] RATIO_UV_MIN = 16'h041f;
	// one over root three, times 1024
	localparam logic [15:0] INV_SQRT3 = 16'h024f;
	// timing: delays are counted in milliseconds
	localparam int CLK_NS   = 20;
	localparam int MS_NS    = 1000000;
	localparam int TICK_CYC = MS_NS / CLK_NS;
	localparam int AVG_WIN_MIN = 10;  // average window, built upstream
	// measuring methods and voting
	typedef enum logic [1:0] {
		METH_FUND = 2'b00,
		METH_RMS  = 2'b01,
		METH_AVG  = 2'b10
	} pve_meth_t;
	typedef enum logic [1:0] {
		VOTE_ONE = 2'b00,
		VOTE_TWO = 2'b01,
		VOTE_ALL = 2'b10
	} pve_vote_t;
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_TIMING = 2'b01,
		ST_TRIP   = 2'b10
	} pve_state_t;
	// three magnitudes, index 0 is phase 1 (or line 1-2)
	typedef logic [2:0][15:0] pve_tri_t;
	typedef struct packed {
		pve_tri_t fund;
		pve_tri_t rms;
		pve_tri_t avg;
		pve_tri_t cur;
	} pve_meas_t;
	typedef struct packed {
		logic [2:0] pickup;
		logic [2:0] trip;
	} pve_msg_t;
endpackage

// >>> pve_element.sv
// Purpose: one over/undervoltage element with voting, hysteresis, delays
// Assumes: measured values synchronous to pclk, line or phase per setting
// Notes:   registers answer two cycles after setup, pready registered
`timescale 1ns/100ps
`default_nettype none
module pve_element
#(
	parameter int TICK_CYC = pve_pkg::TICK_CYC
)
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// measurements and blocking
	input  wire pve_pkg::pve_meas_t meas,
	input  wire logic              ext_block,
	input  wire logic              fuse_fail,
	// messages
	output var  pve_pkg::pve_msg_t msg
);
	import pve_pkg::*;
	logic [9:0]  ctrl;       // mode and option bits
	logic [15:0] transformer_secondary_voltage; // secondary rating
	logic [15:0] thr_pu;     // threshold, per unit of reference
	logic [15:0] ratio;      // dropout ratio, per 1024
	logic [15:0] tdly;       // trip delay in ms
	logic [15:0] imin_thr;   // minimum current
	logic [15:0] imin_dly;   // release delay in ms
	logic [9:0]  next_ctrl;
	logic [15:0] next_transformer_secondary_voltage, next_thr_pu, next_ratio;
	logic [15:0] next_tdly, next_imin_thr, next_imin_dly;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr;
	// decoded settings
	logic en, over, vt_pp, mm_pp, im_en, mcs;
	pve_meth_t meth;
	pve_vote_t vote;
	assign en    = ctrl[CB_EN];
	assign over  = ctrl[CB_OVER];                                   // RL3
	assign meth  = pve_meth_t'(ctrl[CB_METH+:2]);
	assign vt_pp = ctrl[CB_VTPP];
	assign mm_pp = ctrl[CB_MMPP];
	assign vote  = pve_vote_t'(ctrl[CB_VOTE+:2]);
	assign im_en = ctrl[CB_IMEN] && !over;                          // RL8
	assign mcs   = ctrl[CB_MCS];
	// millisecond enable pulse, one cycle wide
	logic [31:0] tick_cnt, next_tick_cnt;
	logic        tick;
	assign tick = (tick_cnt == 32'(TICK_CYC - 1));
	always_comb
	begin
		next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt <= 32'h0;
		else
			tick_cnt <= next_tick_cnt;
	end
	// reference and levels; line connection overrides measuring mode
	logic [15:0] nominal_voltage_ref, thr, rat_eff;
	logic [31:0] prod_nom, prod_thr, prod_drop;
	logic [16:0] drop;
	always_comb
	begin
		prod_nom = transformer_secondary_voltage * INV_SQRT3;
		if (vt_pp || mm_pp)
			nominal_voltage_ref = transformer_secondary_voltage; // RL6 RL7
		else
			nominal_voltage_ref = prod_nom[25:10];               // RL6
		prod_thr = thr_pu * nominal_voltage_ref;
		thr = prod_thr[25:10];
		// the set ratio may only widen the mandatory hysteresis
		if (over)
			rat_eff = (ratio > RATIO_OV_MAX) ? RATIO_OV_MAX : ratio;   // RL13
		else
			rat_eff = (ratio < RATIO_UV_MIN) ? RATIO_UV_MIN : ratio;   // RL14
		prod_drop = thr * rat_eff;                                      // RL12
		drop = prod_drop[26:10];
	end
	// quantity under test, channel n feeds message n
	pve_tri_t vsel;
	always_comb
	begin
		case (meth)
			METH_RMS: vsel = meas.rms;                                  // RL4
			METH_AVG: vsel = meas.avg;                                  // RL5
			default:  vsel = meas.fund;                                 // RL4
		endcase
	end
	// per-phase pickup flags with hysteresis
	logic [2:0] flag, next_flag;
	generate
		for (genvar g = 0; g < 3; g++)
		begin : g_ph
			always_comb
			begin
				if (!en)
					next_flag[g] = 1'b0;
				else if (over)                                          // RL16
					next_flag[g] = flag[g] ? ({1'b0, vsel[g]} > drop)
						: (vsel[g] > thr);                                  // RL13
				else
					next_flag[g] = flag[g] ? ({1'b0, vsel[g]} < drop)
						: (vsel[g] < thr);                                  // RL14
			end
		end
	endgenerate
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag <= 3'h0;
		else
			flag <= next_flag;
	end
	// voting over the three flags
	function automatic logic voted(input logic [2:0] f, input pve_vote_t v);
		logic [1:0] n;
		n = {1'b0, f[0]} + {1'b0, f[1]} + {1'b0, f[2]};
		case (v)
			VOTE_TWO: voted = (n >= 2'd2);
			VOTE_ALL: voted = (n == 2'd3);
			default:  voted = (n != 2'd0);
		endcase
	endfunction
	// minimum-current block and its release delay
	logic        imin_blk, next_imin_blk, all_low;
	logic [15:0] rel_cnt, next_rel_cnt;
	assign all_low = (meas.cur[0] < imin_thr) && (meas.cur[1] < imin_thr)
		&& (meas.cur[2] < imin_thr);
	always_comb
	begin
		next_imin_blk = imin_blk;
		next_rel_cnt  = 16'h0;    // counts only while blocked
		if (!im_en)
			next_imin_blk = 1'b0;                                       // RL8
		else if (all_low)
			next_imin_blk = 1'b1;                                       // RL9
		else if (imin_blk)
		begin
			// a reclosing breaker must not see an instant trip
			if (rel_cnt >= imin_dly)
				next_imin_blk = 1'b0;                                   // RL10
			else
				next_rel_cnt = rel_cnt + {15'h0, tick};                 // RL10
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			imin_blk <= 1'b0;
			rel_cnt  <= 16'h0;
		end
		else
		begin
			imin_blk <= next_imin_blk;
			rel_cnt  <= next_rel_cnt;
		end
	end
	// undervoltage blocking sources; overvoltage is never blocked here
	logic blk, pick;
	assign blk  = !over && (ext_block || (mcs && fuse_fail) || imin_blk); // RL18 RL19
	assign pick = voted(flag, vote) && !blk;                        // RL11
	// trip delay state machine
	pve_state_t st, next_st;
	logic [15:0] tcnt, next_tcnt;
	always_comb
	begin
		next_st   = st;
		next_tcnt = tcnt;
		case (st)
			ST_IDLE:
			begin
				next_tcnt = 16'h0;
				if (pick)
					next_st = ST_TIMING;                                // RL15
			end
			ST_TIMING:
			begin
				if (!pick)
					next_st = ST_IDLE;                                  // RL20
				else if (tcnt >= tdly)
					next_st = ST_TRIP;                                  // RL15 RL17
				else if (tick)
					next_tcnt = tcnt + 16'h1;
			end
			ST_TRIP:
			begin
				if (!pick)
					next_st = ST_IDLE;                                  // RL20
			end
			default: next_st = ST_IDLE;  // idle then clears the count
		endcase
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st   <= ST_IDLE;
			tcnt <= 16'h0;
		end
		else
		begin
			st   <= next_st;
			tcnt <= next_tcnt;
		end
	end
	// messages: index follows the input channel in both connections
	pve_msg_t next_msg;
	always_comb
	begin
		next_msg.pickup = pick ? flag : 3'h0;                           // RL1 RL2
		next_msg.trip   = (next_st == ST_TRIP && next_flag != 3'h0 && pick)
			? flag : 3'h0;                                              // RL1 RL2
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			msg <= '0;
		else
			msg <= next_msg;
	end
	// apb: access phase lasts two cycles, write lands with pready
	logic acc, hit;
	assign acc = psel && penable && pready;
	always_comb
	begin
		next_ctrl = ctrl;
		next_transformer_secondary_voltage = transformer_secondary_voltage;
		next_thr_pu = thr_pu;
		next_ratio = ratio;
		next_tdly = tdly;
		next_imin_thr = imin_thr;
		next_imin_dly = imin_dly;
		next_pready = psel && penable && !pready;
		hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);
		next_pslverr = next_pready && !hit;
		next_prdata = 32'h0;
		if (next_pready)
		begin
			case (paddr)
				OFS_CTRL:   next_prdata = {22'h0, ctrl};
				OFS_VTSEC:  next_prdata = {16'h0,
					transformer_secondary_voltage};
				OFS_THR:    next_prdata = {16'h0, thr_pu};
				OFS_RATIO:  next_prdata = {16'h0, ratio};
				OFS_TDLY:   next_prdata = {16'h0, tdly};
				OFS_IMIN:   next_prdata = {16'h0, imin_thr};
				OFS_IDLY:   next_prdata = {16'h0, imin_dly};
				OFS_STATUS: next_prdata = {25'h0, imin_blk, blk,
					st == ST_TRIP, pick, flag};
				default:    next_prdata = 32'h0;
			endcase
		end
		if (acc && pwrite)
		begin
			case (paddr)
				OFS_CTRL:  next_ctrl = pwdata[9:0];
				OFS_VTSEC: next_transformer_secondary_voltage = pwdata[15:0];
				OFS_THR:   next_thr_pu = pwdata[15:0];
				OFS_RATIO: next_ratio = pwdata[15:0];
				OFS_TDLY:  next_tdly = pwdata[15:0];
				OFS_IMIN:  next_imin_thr = pwdata[15:0];
				OFS_IDLY:  next_imin_dly = pwdata[15:0];
				default:   next_ctrl = ctrl;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= RST_CTRL;
			transformer_secondary_voltage <= RST_VTSEC;
			thr_pu <= RST_THR;
			ratio <= RST_RATIO;
			tdly <= RST_TDLY;
			imin_thr <= RST_IMIN;
			imin_dly <= RST_IDLY;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			ctrl <= next_ctrl;
			transformer_secondary_voltage <=
				next_transformer_secondary_voltage;
			thr_pu <= next_thr_pu;
			ratio <= next_ratio;
			tdly <= next_tdly;
			imin_thr <= next_imin_thr;
			imin_dly <= next_imin_dly;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end
	// checks on the element behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ov_pickup: assert property (en && over && vsel[0] > thr // RL16
		|=> flag[0]) else $error("overvoltage flag missed");
	chk_uv_pickup: assert property (en && !over && vsel[1] < thr // RL16
		|=> flag[1]) else $error("undervoltage flag missed");
	chk_ov_hold: assert property (en && over && flag[2] // RL13
		&& {1'b0, vsel[2]} > drop |=> flag[2])
		else $error("overvoltage released early");
	chk_vote_all: assert property (vote == VOTE_ALL // RL11
		&& flag != 3'h7 |-> !pick) else $error("vote all ignored");
	chk_trip_path: assert property ($rose(st == ST_TRIP) // RL15
		|-> $past(st) == ST_TIMING) else $error("trip without delay");
	chk_trip_drop: assert property (st != ST_IDLE && !pick // RL20
		|=> st == ST_IDLE ##1 msg.trip == 3'h0)
		else $error("trip not cleared");
	chk_ext_block: assert property (!over && ext_block // RL18
		|=> msg.pickup == 3'h0 && msg.trip == 3'h0)
		else $error("external block ignored");
	chk_imin_block: assert property (im_en && all_low // RL9
		|=> imin_blk) else $error("minimum current block missed");
	chk_fuse_block: assert property (!over && mcs && fuse_fail // RL19
		|-> !pick) else $error("fuse failure not blocking");
	cov_trip: cover property (st == ST_TIMING ##1 st == ST_TRIP);
	cov_restart: cover property (st == ST_TIMING ##1 st == ST_IDLE);
	cov_release: cover property ($fell(imin_blk) && im_en);
endmodule
`default_nettype wire

// >>> pve_meas_model.sv
// Purpose: stand-in for the upstream voltage and current measurement
// Assumes: bench sets the magnitudes it wants the element to see
// Notes:   one register stage, like a real filter output
`timescale 1ns/100ps
`default_nettype none
module pve_meas_model
(
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// magnitudes requested by the bench
	input  wire pve_pkg::pve_tri_t v_fund,
	input  wire pve_pkg::pve_tri_t v_rms,
	input  wire pve_pkg::pve_tri_t v_avg,
	input  wire pve_pkg::pve_tri_t cur,
	// measured values toward the element
	output var  pve_pkg::pve_meas_t meas
);
	import pve_pkg::*;
	pve_meas_t next_meas;	// value for the next edge

	// under line connection the bench already hands line voltages
	always_comb
	begin
		next_meas = {v_fund, v_rms, v_avg, cur};
	end

	// results appear one edge late, as from a real filter
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			meas <= '0;
		else
			meas <= next_meas;
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench for the voltage protection element
// Assumes: one apb wait state, ms tick shortened to a few cycles
// Notes:   each scenario is a task that judges its own results
`timescale 1ns/100ps
`default_nettype none
module tb_top;
import pve_pkg::*;
localparam int TK = 4;	// cycles per ms tick, short for run time
localparam int EN = 1, OV = 2, PP = 16, MM = 32, IM = 256, MCS = 512;
localparam logic [15:0] LO = 16'h0100;	// far below any threshold
localparam logic [15:0] HI = 16'h0450;	// above the 1024 threshold
localparam logic [15:0] NM = 16'h0420;	// above the undervoltage band
logic	pclk, presetn, psel, penable, pwrite, ext_block, fuse_fail;
logic	[7:0] paddr;
logic	[31:0] pwdata, prdata, rd;
logic	pready, pslverr, er;
pve_tri_t	v_fund, v_rms, v_avg, cur;
pve_meas_t	meas;
pve_msg_t	msg;
int	miscompares, checks_done, n;

always #10 pclk = ~pclk;

pve_meas_model pve_meas_model_inst (.pclk(pclk), .presetn(presetn),
	.v_fund(v_fund), .v_rms(v_rms), .v_avg(v_avg), .cur(cur),
	.meas(meas));
pve_element #(.TICK_CYC(TK)) pve_element_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .meas(meas), .ext_block(ext_block),
	.fuse_fail(fuse_fail), .msg(msg));

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	checks_done++;
	if (got !== exp)
	begin
		miscompares++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask

// one apb transfer, request held until pready is seen at an edge
task automatic apb(input logic w, input logic [7:0] a,
	input logic [31:0] d);
	int k;
	k = 0;
	@(posedge pclk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'b1;
	do
	begin
		@(posedge pclk);
		k++;
	end
	while (pready !== 1'b1 && k < 20);
	if (k >= 20)
		miscompares++;
	rd = prdata;
	er = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
endtask

task automatic st;
	repeat (6) @(posedge pclk);
endtask

// new magnitudes, then let the pickup path settle
task automatic sv(input pve_tri_t f, r, a);
	@(posedge pclk);
	v_fund <= f;
	v_rms <= r;
	v_avg <= a;
	st();
endtask

// edges until a trip (p=0) or pickup (p=1) bit rises, bounded
task automatic wt(input logic p, input int b);
	n = 0;
	while ((p ? msg.pickup[b] : msg.trip[b]) !== 1'b1 && n < 200)
	begin
		@(posedge pclk);
		n++;
	end
endtask

task automatic t_regs;
	logic [7:0] ofs [7] = '{OFS_CTRL, OFS_VTSEC, OFS_THR, OFS_RATIO,
		OFS_TDLY, OFS_IMIN, OFS_IDLY};
	logic [31:0] rv [7] = '{32'(RST_CTRL), 32'(RST_VTSEC),
		32'(RST_THR), 32'(RST_RATIO), 32'(RST_TDLY), 32'(RST_IMIN),
		32'(RST_IDLY)};
	for (int i = 0; i < 7; i++)
	begin
		apb(1'b0, ofs[i], 32'h0);
		chk(rd, rv[i]);
		chk({31'h0, er}, 32'h0);
	end
	apb(1'b0, 8'h20, 32'h0);
	chk({31'h0, er}, 32'h1);
	chk(rd, 32'h0);
	apb(1'b1, OFS_STATUS, 32'hffffffff);
	apb(1'b0, OFS_STATUS, 32'h0);
	chk(rd, 32'h0);
	apb(1'b1, OFS_VTSEC, 32'h400);
	apb(1'b0, OFS_VTSEC, 32'h0);
	chk(rd, 32'h400);
	$display("test regs done");
endtask

// each method sees a different phase high
task automatic t_meth;
	sv({LO, LO, HI}, {LO, HI, LO}, {HI, LO, LO});
	for (int m = 0; m < 3; m++)
	begin
		apb(1'b1, OFS_CTRL, 32'(EN | OV | PP | (m << 2)));
		st();
		chk(32'(msg.pickup), 32'(1 << m));
	end
	$display("test methods done");
endtask

task automatic t_vote;
	sv({HI, HI, LO}, {3{LO}}, {3{LO}});
	for (int v = 0; v < 3; v++)
	begin
		apb(1'b1, OFS_CTRL, 32'(EN | OV | PP | (v << 6)));
		st();
		chk(32'(msg.pickup), (v == 2) ? 32'h0 : 32'h6);
	end
	sv({3{HI}}, {3{LO}}, {3{LO}});
	chk(32'(msg.pickup), 32'h7);
	$display("test vote done");
endtask

// ground reference is secondary over root three, 591 here
task automatic t_ref;
	sv({LO, LO, 16'h0258}, {3{LO}}, {3{LO}});
	apb(1'b1, OFS_CTRL, 32'(EN | OV));
	st();
	chk(32'(msg.pickup), 32'h1);
	apb(1'b1, OFS_CTRL, 32'(EN | OV | MM));
	st();
	chk(32'(msg.pickup), 32'h0);
	apb(1'b1, OFS_CTRL, 32'(EN | OV | PP));
	st();
	chk(32'(msg.pickup), 32'h0);
	$display("test reference done");
endtask

task automatic t_ovtrip;
	apb(1'b1, OFS_TDLY, 32'h4);
	sv({3{LO}}, {3{LO}}, {3{LO}});
	v_fund[0] <= HI;
	repeat (14) @(posedge pclk);
	chk(32'(msg.trip), 32'h0);
	v_fund[0] <= LO;
	st();
	v_fund[0] <= HI;
	wt(1'b0, 0);
	chk(32'(n >= 15 && n <= 24), 32'h1);
	sv({LO, LO, 16'd994}, {3{LO}}, {3{LO}});
	chk(32'(msg.trip), 32'h1);
	sv({LO, LO, 16'd993}, {3{LO}}, {3{LO}});
	chk(32'(msg.trip | msg.pickup), 32'h0);
	apb(1'b1, OFS_RATIO, 32'h300);
	sv({LO, LO, HI}, {3{LO}}, {3{LO}});
	sv({LO, LO, 16'h0384}, {3{LO}}, {3{LO}});
	chk(32'(msg.pickup), 32'h1);
	sv({LO, LO, 16'h02bc}, {3{LO}}, {3{LO}});
	chk(32'(msg.pickup), 32'h0);
	$display("test overvoltage trip done");
endtask

task automatic t_uv;
	apb(1'b1, OFS_CTRL, 32'(EN | PP | (1 << 2) | MCS));
	apb(1'b1, OFS_IMIN, 32'h100);
	apb(1'b1, OFS_IDLY, 32'h2);
	cur <= {3{16'h0200}};
	sv({3{HI}}, {16'h0200, NM, NM}, {3{HI}});
	chk(32'(msg.pickup), 32'h4);
	sv({3{HI}}, {16'd1054, NM, NM}, {3{HI}});
	chk(32'(msg.pickup), 32'h4);
	sv({3{HI}}, {16'd1055, NM, NM}, {3{HI}});
	chk(32'(msg.pickup), 32'h0);
	sv({3{HI}}, {16'h0200, NM, NM}, {3{HI}});
	ext_block <= 1'b1;
	st();
	chk(32'(msg.pickup), 32'h0);
	ext_block <= 1'b0;
	fuse_fail <= 1'b1;
	st();
	chk(32'(msg.pickup), 32'h0);
	fuse_fail <= 1'b0;
	cur <= {3{16'h0050}};
	st();
	chk(32'(msg.pickup), 32'h4);
	apb(1'b1, OFS_CTRL, 32'(EN | PP | (1 << 2) | MCS | IM));
	st();
	chk(32'(msg.pickup), 32'h0);
	cur[0] <= 16'h0200;
	wt(1'b1, 2);
	chk(32'(n >= TK + 2 && n <= 4 * TK + 4), 32'h1);
	$display("test undervoltage done");
endtask

task automatic wrap_up;
	$display("checks %0d mismatches %0d", checks_done, miscompares);
	if (miscompares == 0 && checks_done > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask

// cut a hang short well beyond the expected run length
initial
begin
	#400000;
	miscompares++;
	wrap_up();
end

initial
begin
	pclk = 1'b0;
	presetn = 1'b0;
	{psel, penable, pwrite, ext_block, fuse_fail} = '0;
	paddr = '0;
	pwdata = '0;
	{v_fund, v_rms, v_avg, cur} = '0;
	repeat (3) @(posedge pclk);
	presetn <= 1'b1;
	t_regs();
	t_meth();
	t_vote();
	t_ref();
	t_ovtrip();
	t_uv();
	wrap_up();
end
endmodule
`default_nettype wire
